// ---- logic/aggregator_regs.svh ----
// register offsets, reset values and field positions of the global
// interrupt aggregator; definitions only, included by bare name
`ifndef AGGREGATOR_REGS_SVH
`define AGGREGATOR_REGS_SVH

// register offsets on the host register port
`define OFS_SERIAL_IRQ_ENABLE 8'h06
`define OFS_SERIAL_IRQ_STATUS 8'h07
`define OFS_ETH_IRQ_ENABLE 8'h08
`define OFS_ETH_IRQ_STATUS 8'h09
`define OFS_QUEUE_IRQ_ENABLE 8'h0a
`define OFS_QUEUE_IRQ_STATUS 8'h0b
`define OFS_TESTER_IRQ_ENABLE 8'h0c
`define OFS_TESTER_IRQ_STATUS 8'h0d
`define OFS_ETH1_CONN_SELECT 8'h0e
`define OFS_GROUP_EVENT 8'h20
`define OFS_GROUP_MASK 8'h21

// reset values
`define RST_REG8 8'h00
`define RST_GROUP4 4'h0
`define RST_ETH1_SELECT 3'h1

// group event bit positions
`define GRP_SERIAL 0
`define GRP_ETH 1
`define GRP_QUEUE 2
`define GRP_TESTER 3

// synchroniser depth for pin inputs
`define SYNC_STAGES 2

`endif

// ---- logic/aggregator_pkg.sv ----
// types shared by the global interrupt aggregator files
// assumes aggregator_regs.svh supplies the numeric constants
package aggregator_pkg;

    // per-interface serial event levels, index 0 is interface 1
    typedef struct packed {
        logic [3:0] hdlc_tx;
        logic [3:0] x86_tx;
        logic [3:0] hdlc_rx;
        logic [3:0] x86_rx;
    } serial_events_t;

    // ethernet interface levels: mac and rmii/mii port
    typedef struct packed {
        logic [3:0] mac;
        logic [3:0] mii;
    } eth_events_t;

    // queue threshold and overflow levels
    typedef struct packed {
        logic [3:0] tx_thresh;
        logic [3:0] tx_ovf;
        logic [3:0] rx_thresh;
        logic [3:0] rx_ovf;
    } queue_events_t;

    // decoded ethernet 1 connection
    typedef enum logic [2:0] {
        LINK_OFF,
        LINK_S1,
        LINK_S2,
        LINK_S3,
        LINK_S4
    } link_sel_t;

endpackage

// ---- logic/summary_gate.sv ----
// one summary status group: two event sources or-ed and gated by enables
// assumes sources come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module summary_gate #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] src_a,
    input wire logic [W-1:0] src_b,
    input wire logic [W-1:0] enable,
    output logic [W-1:0] status
);

    logic [W-1:0] next_status;

    // status follows enabled sources, no write path
    always_comb
    begin
        next_status = (src_a | src_b) & enable;
    end

    // register the summary
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            status <= '0;
        else
            status <= next_status;
    end

endmodule

`default_nettype wire

// ---- logic/global_interrupt_aggregator.sv ----
// global interrupt aggregator with ethernet 1 connection selector
// assumes event sources on clk, serial pins asynchronous to clk
//
// Summary of operation
// [R01] serial status bits: tx 7..4, rx 3..0
// [R02] serial status from hdlc and x86 events
// [R03] ethernet enables in bits 3..0
// [R04] ethernet status from mac and mii events
// [R05] queue enables: tx 7..4, rx 3..0
// [R06] tx queue status on threshold or overflow
// [R07] rx queue status on threshold or overflow
// [R08] tester enable at bit 0
// [R09] tester status at bit 0 on enabled event
// [R10] ethernet 1 selector bits 2..0, resets 1
// [R11] selector 0 disconnects, 1..4 pick serial line
// [R12] disconnected: data ones, hdlc clocks low
// [R13] serial enables gate serial status bits
// [R14] interrupt pin drives low when active
// [R15] interrupt active while any status set
// [R16] status registers read only, writes ignored
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "aggregator_regs.svh"

module global_interrupt_aggregator (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire aggregator_pkg::serial_events_t serial_events,
    input wire aggregator_pkg::eth_events_t eth_events,
    input wire aggregator_pkg::queue_events_t queue_events,
    input wire logic tester_event,
    input wire logic hdlc1_tx_data,
    input wire logic [3:0] serial_rx_data_pin,
    input wire logic [3:0] serial_rx_clk_pin,
    input wire logic [3:0] serial_tx_clk_pin,
    output logic conn1_line_tx,
    output logic [3:0] conn1_line_sel,
    output logic conn1_hdlc_rx_data,
    output logic conn1_hdlc_tx_clk,
    output logic conn1_hdlc_rx_clk,
    output logic int_n,
    output logic irq
);
    import aggregator_pkg::*;

    logic [7:0] serial_en;
    logic [3:0] eth_en;
    logic [7:0] queue_en;
    logic tester_en;
    logic [2:0] eth1_serial_selector;
    logic [3:0] group_mask;
    logic [7:0] next_serial_en;
    logic [3:0] next_eth_en;
    logic [7:0] next_queue_en;
    logic next_tester_en;
    logic [2:0] next_eth1_serial_selector;
    logic [3:0] next_group_mask;
    logic [7:0] next_reg_rdata;
    logic [7:0] serial_status;
    logic [3:0] eth_status;
    logic [7:0] queue_status;
    logic [0:0] tester_status;
    logic [3:0] group_event;
    logic [3:0] group_prev;
    logic [3:0] group_any;
    logic [3:0] group_clear;
    logic [3:0] next_group_event;
    logic next_int_n;
    logic next_irq;
    logic wr_hit_event;
    logic [3:0] sync1_rx_data;
    logic [3:0] sync2_rx_data;
    logic [3:0] sync1_rx_clk;
    logic [3:0] sync2_rx_clk;
    logic [3:0] sync1_tx_clk;
    logic [3:0] sync2_tx_clk;
    link_sel_t link;
    logic [1:0] link_idx;
    logic next_line_tx;
    logic [3:0] next_line_sel;
    logic next_hdlc_rx_data;
    logic next_hdlc_tx_clk;
    logic next_hdlc_rx_clk;

    // enabled event summaries per group
    summary_gate #(.W(8)) serial_gate (  // see [R01] see [R02] see [R13]
        .clk(clk),
        .arst_n(arst_n),
        .src_a({serial_events.hdlc_tx, serial_events.hdlc_rx}),
        .src_b({serial_events.x86_tx, serial_events.x86_rx}),
        .enable(serial_en),
        .status(serial_status)
    );
    summary_gate #(.W(4)) eth_gate (  // see [R04]
        .clk(clk),
        .arst_n(arst_n),
        .src_a(eth_events.mac),
        .src_b(eth_events.mii),
        .enable(eth_en),
        .status(eth_status)
    );
    summary_gate #(.W(8)) queue_gate (  // see [R06] see [R07]
        .clk(clk),
        .arst_n(arst_n),
        .src_a({queue_events.tx_thresh, queue_events.rx_thresh}),
        .src_b({queue_events.tx_ovf, queue_events.rx_ovf}),
        .enable(queue_en),
        .status(queue_status)
    );
    summary_gate #(.W(1)) tester_gate (  // see [R09]
        .clk(clk),
        .arst_n(arst_n),
        .src_a(tester_event),
        .src_b(1'b0),
        .enable(tester_en),
        .status(tester_status)
    );

    // host register port: writes to enables, selector, mask; read mux
    always_comb
    begin
        next_serial_en = serial_en;
        next_eth_en = eth_en;
        next_queue_en = queue_en;
        next_tester_en = tester_en;
        next_eth1_serial_selector = eth1_serial_selector;
        next_group_mask = group_mask;
        next_reg_rdata = `RST_REG8;
        if (reg_wr)
        begin
            // status offsets have no write path, see [R16]
            unique case (reg_addr)
                `OFS_SERIAL_IRQ_ENABLE: next_serial_en = reg_wdata;
                `OFS_ETH_IRQ_ENABLE: next_eth_en = reg_wdata[3:0];  // see [R03]
                `OFS_QUEUE_IRQ_ENABLE: next_queue_en = reg_wdata;  // see [R05]
                `OFS_TESTER_IRQ_ENABLE: next_tester_en = reg_wdata[0];  // see [R08]
                `OFS_ETH1_CONN_SELECT: next_eth1_serial_selector = reg_wdata[2:0];  // see [R10]
                `OFS_GROUP_MASK: next_group_mask = reg_wdata[3:0];
                default: next_serial_en = serial_en;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                `OFS_SERIAL_IRQ_ENABLE: next_reg_rdata = serial_en;
                `OFS_SERIAL_IRQ_STATUS: next_reg_rdata = serial_status;
                `OFS_ETH_IRQ_ENABLE: next_reg_rdata = {4'h0, eth_en};
                `OFS_ETH_IRQ_STATUS: next_reg_rdata = {4'h0, eth_status};
                `OFS_QUEUE_IRQ_ENABLE: next_reg_rdata = queue_en;
                `OFS_QUEUE_IRQ_STATUS: next_reg_rdata = queue_status;
                `OFS_TESTER_IRQ_ENABLE: next_reg_rdata = {7'h00, tester_en};
                `OFS_TESTER_IRQ_STATUS: next_reg_rdata = {7'h00, tester_status};
                `OFS_ETH1_CONN_SELECT: next_reg_rdata = {5'h00, eth1_serial_selector};
                `OFS_GROUP_EVENT: next_reg_rdata = {4'h0, group_event};
                `OFS_GROUP_MASK: next_reg_rdata = {4'h0, group_mask};
                default: next_reg_rdata = `RST_REG8;
            endcase
        end
    end

    // register file state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            serial_en <= `RST_REG8;
            eth_en <= `RST_GROUP4;
            queue_en <= `RST_REG8;
            tester_en <= 1'b0;
            eth1_serial_selector <= `RST_ETH1_SELECT;  // see [R10]
            group_mask <= `RST_GROUP4;
            reg_rdata <= `RST_REG8;
        end
        else
        begin
            serial_en <= next_serial_en;
            eth_en <= next_eth_en;
            queue_en <= next_queue_en;
            tester_en <= next_tester_en;
            eth1_serial_selector <= next_eth1_serial_selector;
            group_mask <= next_group_mask;
            reg_rdata <= next_reg_rdata;
        end
    end

    // sticky group events, rising edge of each group's summary
    always_comb
    begin
        group_any[`GRP_SERIAL] = |serial_status;
        group_any[`GRP_ETH] = |eth_status;
        group_any[`GRP_QUEUE] = |queue_status;
        group_any[`GRP_TESTER] = tester_status[0];
        wr_hit_event = reg_wr && (reg_addr == `OFS_GROUP_EVENT);
        group_clear = wr_hit_event ? reg_wdata[3:0] : 4'h0;
        // a new edge wins over a write-one clear in the same cycle
        next_group_event = (group_event & ~group_clear) | (group_any & ~group_prev);
        next_irq = |(next_group_event & group_mask);
        next_int_n = ~(|{serial_status, eth_status, queue_status, tester_status});  // see [R15]
    end

    // interrupt state and outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            group_event <= `RST_GROUP4;
            group_prev <= `RST_GROUP4;
            irq <= 1'b0;
            int_n <= 1'b1;
        end
        else
        begin
            group_event <= next_group_event;
            group_prev <= group_any;
            irq <= next_irq;
            int_n <= next_int_n;  // see [R14]
        end
    end

    // two-flop synchronisers for the serial pins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_rx_data <= 4'hf;
            sync2_rx_data <= 4'hf;
            sync1_rx_clk <= 4'h0;
            sync2_rx_clk <= 4'h0;
            sync1_tx_clk <= 4'h0;
            sync2_tx_clk <= 4'h0;
        end
        else
        begin
            sync1_rx_data <= serial_rx_data_pin;
            sync2_rx_data <= sync1_rx_data;
            sync1_rx_clk <= serial_rx_clk_pin;
            sync2_rx_clk <= sync1_rx_clk;
            sync1_tx_clk <= serial_tx_clk_pin;
            sync2_tx_clk <= sync1_tx_clk;
        end
    end

    // selector decode and connection path
    always_comb
    begin
        unique case (eth1_serial_selector)  // see [R11]
            3'h1: link = LINK_S1;
            3'h2: link = LINK_S2;
            3'h3: link = LINK_S3;
            3'h4: link = LINK_S4;
            default: link = LINK_OFF;
        endcase
        link_idx = eth1_serial_selector[1:0] - 2'h1;
        if (link == LINK_OFF)
        begin
            // idle ones on data, hdlc clocks stopped, see [R12]
            next_line_tx = 1'b1;
            next_line_sel = 4'h0;
            next_hdlc_rx_data = 1'b1;
            next_hdlc_tx_clk = 1'b0;
            next_hdlc_rx_clk = 1'b0;
        end
        else
        begin
            next_line_tx = hdlc1_tx_data;
            next_line_sel = 4'h1 << link_idx;
            next_hdlc_rx_data = sync2_rx_data[link_idx];
            next_hdlc_tx_clk = sync2_tx_clk[link_idx];
            next_hdlc_rx_clk = sync2_rx_clk[link_idx];
        end
    end

    // connection outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            conn1_line_tx <= 1'b1;
            conn1_line_sel <= 4'h0;
            conn1_hdlc_rx_data <= 1'b1;
            conn1_hdlc_tx_clk <= 1'b0;
            conn1_hdlc_rx_clk <= 1'b0;
        end
        else
        begin
            conn1_line_tx <= next_line_tx;
            conn1_line_sel <= next_line_sel;
            conn1_hdlc_rx_data <= next_hdlc_rx_data;
            conn1_hdlc_tx_clk <= next_hdlc_tx_clk;
            conn1_hdlc_rx_clk <= next_hdlc_rx_clk;
        end
    end

    // helper values watched by the checks below
    logic [7:0] serial_want;
    logic [3:0] eth_want;
    logic [7:0] queue_want;
    logic tester_want;
    logic [2:0] wdata_sel;
    logic status_any;
    assign serial_want = ({serial_events.hdlc_tx, serial_events.hdlc_rx}
        | {serial_events.x86_tx, serial_events.x86_rx}) & serial_en;
    assign eth_want = (eth_events.mac | eth_events.mii) & eth_en;
    assign queue_want = ({queue_events.tx_thresh, queue_events.rx_thresh}
        | {queue_events.tx_ovf, queue_events.rx_ovf}) & queue_en;
    assign tester_want = tester_event & tester_en;
    assign wdata_sel = reg_wdata[2:0];
    assign status_any = |{serial_status, eth_status, queue_status, tester_status};

    property p_serial_status;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> serial_status == $past(serial_want);
    endproperty
    a_serial_status: assert property (p_serial_status)  // see [R01] see [R02] see [R13]
        else $error("serial summary does not follow enabled events");

    property p_eth_status;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> eth_status == $past(eth_want);
    endproperty
    a_eth_status: assert property (p_eth_status)  // see [R04]
        else $error("ethernet summary does not follow enabled events");

    property p_txq_status;
        @(posedge clk) disable iff (!arst_n)
        (queue_events.tx_ovf[3] && queue_en[7]) |=> queue_status[7];
    endproperty
    a_txq_status: assert property (p_txq_status)  // see [R06]
        else $error("tx queue 4 overflow not reported");

    property p_rxq_status;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> queue_status[3:0] == $past(queue_want[3:0]);
    endproperty
    a_rxq_status: assert property (p_rxq_status)  // see [R07]
        else $error("rx queue summary wrong");

    property p_tester_status;
        @(posedge clk) disable iff (!arst_n)
        tester_want |=> tester_status[0] ##1 (!int_n || $past(tester_want, 2) == 1'b0);
    endproperty
    a_tester_status: assert property (p_tester_status)  // see [R08] see [R09]
        else $error("tester event not reported or not driving interrupt");

    property p_int_level;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> int_n == !$past(status_any);
    endproperty
    a_int_level: assert property (p_int_level)  // see [R14] see [R15]
        else $error("interrupt pin level disagrees with summaries");

    property p_sel_write;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == `OFS_ETH1_CONN_SELECT) |=> eth1_serial_selector == $past(wdata_sel);
    endproperty
    a_sel_write: assert property (p_sel_write)  // see [R10]
        else $error("selector write not stored");

    property p_link_s1;
        @(posedge clk) disable iff (!arst_n)
        // sampled reset keeps the release edge, still resetting the outputs, out
        (arst_n && eth1_serial_selector == 3'h1) |=> conn1_line_sel == 4'h1
            && conn1_line_tx == $past(hdlc1_tx_data);
    endproperty
    a_link_s1: assert property (p_link_s1)  // see [R11]
        else $error("selector 1 not routed to serial line 1");

    property p_disconnect;
        @(posedge clk) disable iff (!arst_n)
        (link == LINK_OFF) |=> conn1_line_tx && conn1_hdlc_rx_data
            && !conn1_hdlc_tx_clk && !conn1_hdlc_rx_clk && conn1_line_sel == 4'h0;
    endproperty
    a_disconnect: assert property (p_disconnect)  // see [R12]
        else $error("disconnected link not idled");

    property p_status_read;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == `OFS_ETH_IRQ_STATUS) |=> reg_rdata == {4'h0, $past(eth_status)};
    endproperty
    a_status_read: assert property (p_status_read)  // see [R16] see [R03]
        else $error("ethernet status read returns wrong value");

    property p_event_sticky;
        @(posedge clk) disable iff (!arst_n)
        !(reg_wr && reg_addr == `OFS_GROUP_EVENT)
            |=> (group_event & $past(group_event)) == $past(group_event);
    endproperty
    a_event_sticky: assert property (p_event_sticky)
        else $error("group event bit lost without clear");

    property p_rdata_idle;
        @(posedge clk) disable iff (!arst_n)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");

endmodule

`default_nettype wire

// ---- testbench/global_interrupt_aggregator_tb.sv ----
// self-checking bench for the global interrupt aggregator
// assumes the package, the offsets header and the design compile first
`timescale 1ns/1ps
`default_nettype none
`include "aggregator_regs.svh"

module global_interrupt_aggregator_tb;
    import aggregator_pkg::*;

    logic clk;
    logic arst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    serial_events_t serial_events;
    eth_events_t eth_events;
    queue_events_t queue_events;
    logic tester_event;
    logic hdlc1_tx_data;
    logic [3:0] serial_rx_data_pin;
    logic [3:0] serial_rx_clk_pin;
    logic [3:0] serial_tx_clk_pin;
    logic conn1_line_tx;
    logic [3:0] conn1_line_sel;
    logic conn1_hdlc_rx_data;
    logic conn1_hdlc_tx_clk;
    logic conn1_hdlc_rx_clk;
    logic int_n;
    logic irq;
    logic rd_seen;
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 75058;
    logic [7:0] exp_q[$];
    string name_q[$];
    // reset value table, the last two offsets are unmapped
    logic [7:0] def_addr[13] = '{`OFS_SERIAL_IRQ_ENABLE, `OFS_SERIAL_IRQ_STATUS,
        `OFS_ETH_IRQ_ENABLE, `OFS_ETH_IRQ_STATUS, `OFS_QUEUE_IRQ_ENABLE,
        `OFS_QUEUE_IRQ_STATUS, `OFS_TESTER_IRQ_ENABLE, `OFS_TESTER_IRQ_STATUS,
        `OFS_ETH1_CONN_SELECT, `OFS_GROUP_EVENT, `OFS_GROUP_MASK, 8'h05, 8'h30};

    global_interrupt_aggregator global_interrupt_aggregator_inst (
        .clk(clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .serial_events(serial_events),
        .eth_events(eth_events),
        .queue_events(queue_events),
        .tester_event(tester_event),
        .hdlc1_tx_data(hdlc1_tx_data),
        .serial_rx_data_pin(serial_rx_data_pin),
        .serial_rx_clk_pin(serial_rx_clk_pin),
        .serial_tx_clk_pin(serial_tx_clk_pin),
        .conn1_line_tx(conn1_line_tx),
        .conn1_line_sel(conn1_line_sel),
        .conn1_hdlc_rx_data(conn1_hdlc_rx_data),
        .conn1_hdlc_tx_clk(conn1_hdlc_tx_clk),
        .conn1_hdlc_rx_clk(conn1_hdlc_rx_clk),
        .int_n(int_n),
        .irq(irq)
    );

    // 20 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // compare tasks, one per result width
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_byte(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic settle();
        @(negedge clk);
    endtask

    // one-cycle write strobe beside address and data
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read strobe; the expected answer is noted for the monitor
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(exp);
        name_q.push_back(what);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // remembers a sampled read strobe so the answer is taken next cycle
    always @(posedge clk)
    begin
        rd_seen <= reg_rd & arst_n;
    end

    // read data stand only in the cycle after the strobe, compared mid-cycle
    always @(negedge clk)
    begin
        if (rd_seen === 1'b1 && exp_q.size() > 0)
        begin
            check_byte(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
        end
    end

    task automatic check_defaults();
        for (int i = 0; i < 13; i++)
        begin
            rd_reg(def_addr[i], (i == 8) ? 8'h01 : 8'h00, "reset value");
        end
    endtask

    // random sources and enables, seen through enables, status and int_n
    task automatic status_round();
        logic [31:0] r;
        logic [31:0] en;
        logic [7:0] s_ser, s_eth, s_que, s_tst;
        r = $random(seed);
        en = $random(seed);
        serial_events <= r[15:0];
        eth_events <= r[23:16];
        tester_event <= r[24];
        queue_events <= r[31:16] ^ en[15:0];
        wr_reg(`OFS_SERIAL_IRQ_ENABLE, en[7:0]);
        wr_reg(`OFS_ETH_IRQ_ENABLE, en[15:8]);
        wr_reg(`OFS_QUEUE_IRQ_ENABLE, en[23:16]);
        wr_reg(`OFS_TESTER_IRQ_ENABLE, en[31:24]);
        cyc(2);
        s_ser = {serial_events.hdlc_tx | serial_events.x86_tx,
            serial_events.hdlc_rx | serial_events.x86_rx} & en[7:0];
        s_eth = {4'h0, (eth_events.mac | eth_events.mii) & en[11:8]};
        s_que = {queue_events.tx_thresh | queue_events.tx_ovf,
            queue_events.rx_thresh | queue_events.rx_ovf} & en[23:16];
        s_tst = {7'h00, tester_event & en[24]};
        rd_reg(`OFS_SERIAL_IRQ_ENABLE, en[7:0], "serial enable");
        rd_reg(`OFS_ETH_IRQ_ENABLE, {4'h0, en[11:8]}, "eth enable");
        rd_reg(`OFS_QUEUE_IRQ_ENABLE, en[23:16], "queue enable");
        rd_reg(`OFS_TESTER_IRQ_ENABLE, {7'h00, en[24]}, "tester enable");
        for (int k = 0; k < 2; k++)
        begin
            rd_reg(`OFS_SERIAL_IRQ_STATUS, s_ser, "serial status");
            rd_reg(`OFS_ETH_IRQ_STATUS, s_eth, "eth status");
            rd_reg(`OFS_QUEUE_IRQ_STATUS, s_que, "queue status");
            rd_reg(`OFS_TESTER_IRQ_STATUS, s_tst, "tester status");
            wr_reg(`OFS_SERIAL_IRQ_STATUS, ~s_ser);
            wr_reg(`OFS_ETH_IRQ_STATUS, ~s_eth);
            wr_reg(`OFS_QUEUE_IRQ_STATUS, ~s_que);
            wr_reg(`OFS_TESTER_IRQ_STATUS, ~s_tst);
        end
        settle();
        check_bit("int_n", ~|{s_ser, s_eth, s_que, s_tst}, int_n);
    endtask

    // sticky group event, masking and write-one clear of the irq line
    task automatic irq_round();
        @(posedge clk);
        serial_events <= '0;
        queue_events <= '0;
        eth_events <= '0;
        tester_event <= 1'b0;
        wr_reg(`OFS_ETH_IRQ_ENABLE, 8'h0f);
        wr_reg(`OFS_GROUP_MASK, 8'h0f);
        cyc(3);
        wr_reg(`OFS_GROUP_EVENT, 8'h0f);
        cyc(2);
        settle();
        check_bit("int_n idle", 1'b1, int_n);
        check_bit("irq idle", 1'b0, irq);
        @(posedge clk);
        eth_events.mii[2] <= 1'b1;
        cyc(3);
        settle();
        check_bit("int_n active", 1'b0, int_n);
        check_bit("irq raised", 1'b1, irq);
        rd_reg(`OFS_GROUP_EVENT, 8'h02, "group event");
        eth_events.mii[2] <= 1'b0;
        cyc(3);
        settle();
        check_bit("int_n released", 1'b1, int_n);
        check_bit("irq sticky", 1'b1, irq);
        rd_reg(`OFS_ETH_IRQ_STATUS, 8'h00, "eth status");
        wr_reg(`OFS_GROUP_MASK, 8'h0d);
        cyc(2);
        settle();
        check_bit("irq masked", 1'b0, irq);
        wr_reg(`OFS_GROUP_MASK, 8'h0f);
        cyc(2);
        settle();
        check_bit("irq unmasked", 1'b1, irq);
        wr_reg(`OFS_GROUP_EVENT, 8'h02);
        cyc(2);
        settle();
        check_bit("irq cleared", 1'b0, irq);
        rd_reg(`OFS_GROUP_EVENT, 8'h00, "group event");
    endtask

    // every selector value twice, with random line traffic
    task automatic conn_round();
        logic [31:0] r;
        logic [2:0] sel;
        logic on;
        int k;
        for (int i = 0; i < 16; i++)
        begin
            r = $random(seed);
            sel = i[2:0];
            on = (sel >= 3'h1) && (sel <= 3'h4);
            k = on ? int'(sel) - 1 : 0;
            wr_reg(`OFS_ETH1_CONN_SELECT, {r[7:3], sel});
            hdlc1_tx_data <= r[8];
            serial_rx_data_pin <= r[12:9];
            serial_rx_clk_pin <= r[16:13];
            serial_tx_clk_pin <= r[20:17];
            cyc(4);
            settle();
            check_bit("line tx", on ? r[8] : 1'b1, conn1_line_tx);
            check_byte("line sel", {4'h0, on ? 4'h1 << k : 4'h0}, {4'h0, conn1_line_sel});
            check_bit("rx data", on ? r[9 + k] : 1'b1, conn1_hdlc_rx_data);
            check_bit("rx clk", on ? r[13 + k] : 1'b0, conn1_hdlc_rx_clk);
            check_bit("tx clk", on ? r[17 + k] : 1'b0, conn1_hdlc_tx_clk);
            rd_reg(`OFS_ETH1_CONN_SELECT, {5'h00, sel}, "selector");
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial
    begin
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        serial_events = '0;
        eth_events = '0;
        queue_events = '0;
        tester_event = 1'b0;
        hdlc1_tx_data = 1'b1;
        serial_rx_data_pin = 4'hf;
        serial_rx_clk_pin = 4'h0;
        serial_tx_clk_pin = 4'h0;
        repeat (6) @(posedge clk);
        check_bit("int_n in reset", 1'b1, int_n);
        arst_n <= 1'b1;
        check_defaults();
        repeat (10) status_round();
        irq_round();
        conn_round();
        @(posedge clk);
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        check_defaults();
        cyc(3);
        tally_and_finish();
    end

    // cuts a hang short well beyond the expected run length
    initial
    begin
        repeat (8000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

endmodule

`default_nettype wire
